/* File: host_bus_model.sv */
/*
  Host model: master on the two-wire register port.
  Assumes an open-drain data line with a pull-up outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "regulator_ctrl_regs.vh"
module host_bus_model (
  input wire logic clock,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic [6:0] addr = `SLAVE_ADDR; // Slave address sent
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter bit, wider than the minimum phase
  task automatic half;
    repeat (3) @(negedge clock);
  endtask
  // Data moves mid low phase, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    half;
    sda_low = !b;
    half;
    scl = 1'b1;
    half;
    r = sda;
    half;
    scl = 1'b0;
  endtask
  // Start or repeated start
  task automatic start;
    half;
    sda_low = 1'b0;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b0;
  endtask
  // Stop condition
  task automatic stop;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b0;
    half;
  endtask
  // One byte out and in, then the ninth bit
  task automatic byte_io(input logic [7:0] d, input logic last,
    output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q = {q[6:0], r};
    end
    bit_io(last, r);
    ack = !r;
  endtask
  task automatic write_reg(input logic [7:0] p, d, output logic ok);
    logic [7:0] q;
    logic a, b, c;
    start;
    byte_io({addr, 1'b0}, 1'b1, q, a);
    byte_io(p, 1'b1, q, b);
    byte_io(d, 1'b1, q, c);
    stop;
    ok = a & b & c;
  endtask
  // Pointer phase is skipped when use_ptr is low
  task automatic read_reg(input logic [7:0] p, input logic use_ptr,
    output logic [7:0] d);
    logic [7:0] q;
    logic a;
    if (use_ptr) begin
      start;
      byte_io({addr, 1'b0}, 1'b1, q, a);
      byte_io(p, 1'b1, q, a);
    end
    start;
    byte_io({addr, 1'b1}, 1'b1, q, a);
    byte_io(8'hFF, 1'b1, d, a);
    stop;
  endtask
endmodule
`default_nettype wire

/* File: regulator_control_registers.v */
/*
  Control register bank of a multi-phase step-down regulator, reached
  over a two-wire serial slave port, plus the control outputs it steers.
  Assumes a 10 MHz clock; all pins arrive asynchronously and are
  synchronised here. The serial data pin is open drain, resolved outside.
*/
// Functional notes
// - Faults restore all three registers' defaults.
// - Converter on if enable bit or pin.
// - Normal code sets target when select inactive.
// - Alternate code sets target when select active.
// - Control bit 7 enables remote sense.
// - Control bit 6 forces pulse mode always.
// - Bit 5 low forces pulse mode when falling while converter on.
// - Bit 4 discharges output while converter off.
// - Bias stays on via bit 3 or pin.
// - Bit 2 lowers switching frequency.
// - Slew field selects select rates; only its fast value 11 also sets the startup rate.
// - Stop condition resets register pointer to zero.
`timescale 1ns/1ns
`default_nettype none
`include "regulator_ctrl_regs.vh"

module regulator_control_registers #(
  parameter [6:0] SLAVE_ADDR = `SLAVE_ADDR,
  parameter SYNC_W = 7
) (
  input wire clock,
  input wire reset_n,
  input wire clock_enable,
  input wire scl_pin,
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_r,
  input wire enable_pin,
  input wire voltage_select_pin,
  input wire bias_keep_pin,
  input wire supply_undervoltage_lockout,
  input wire thermal_shutdown,
  output reg converter_on_r,
  output reg remote_sense_on_r,
  output reg forced_pulse_mode_r,
  output reg discharge_on_r,
  output reg bias_keep_alive_r,
  output reg switching_rate_lower_r,
  output wire [6:0] target_code,
  output reg [1:0] ramp_rate_r
);

  // Serial port states
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK_A = 3'd2;
  localparam ST_WRITE = 3'd3;
  localparam ST_ACK_W = 3'd4;
  localparam ST_READ = 3'd5;
  localparam ST_ACK_R = 3'd6;

  // Two-stage synchronisers for every pin
  reg [SYNC_W-1:0] sync1_r;
  reg [SYNC_W-1:0] sync2_r;
  // Delayed clock and data for edge detection
  reg scl_d_r;
  reg sda_d_r;
  // Serial engine state
  reg [2:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] pointer_r;
  reg first_r;
  reg read_r;
  reg nack_r;
  // The three registers
  reg [7:0] normal_r;
  reg [7:0] alt_r;
  reg [7:0] ctrl_r;
  // Ramp start-up mode
  reg startup_r;
  // Read data for the current pointer
  reg [7:0] rd_data;

  // Synchronised pin levels
  wire scl_s = sync2_r[0];
  wire sda_s = sync2_r[1];
  wire en_s = sync2_r[2];
  wire vsel_s = sync2_r[3];
  wire bias_s = sync2_r[4];
  wire fault_s = sync2_r[5] | sync2_r[6];
  // Bus events
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // Converter request, selected code and ramp goal
  wire conv_req = normal_r[`BIT_EN] | en_s;
  wire [6:0] sel_code = vsel_s ? alt_r[`CODE_MSB:0] : normal_r[`CODE_MSB:0];
  wire [6:0] goal = converter_on_r ? sel_code : 7'h00;
  wire falling;
  wire [SYNC_W-1:0] pins = {thermal_shutdown, supply_undervoltage_lockout,
    bias_keep_pin, voltage_select_pin, enable_pin, sda_in, scl_pin};

  // Per-pin two-flop synchroniser; resets to each pin's idle level, bus high, others low
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          sync1_r[gi] <= (gi < 2);
          sync2_r[gi] <= (gi < 2);
        end else if (clock_enable) begin
          sync1_r[gi] <= pins[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // Register read mux; unmapped offsets read zero
  always @* begin
    case (pointer_r)
      `OFS_NORMAL: rd_data = normal_r;
      `OFS_ALT: rd_data = alt_r;
      `OFS_CTRL1: rd_data = ctrl_r;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial slave engine and register storage
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      pointer_r <= `PTR_IDLE;
      first_r <= 1'b1;
      read_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      normal_r <= `RST_NORMAL;
      alt_r <= `RST_ALT;
      ctrl_r <= `RST_CTRL1;
    end else if (clock_enable) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (stop_det) begin
        // pointer back to zero on stop
        pointer_r <= `PTR_IDLE;
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_det) begin
        // Start or repeated start: expect an address
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        first_r <= 1'b1;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_WRITE: begin
            // Shift in on rising clock
            if (scl_rise && bit_cnt_r != 4'h8) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 1'b1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                // Acknowledge only our own address
                if (shift_r[7:1] == SLAVE_ADDR) begin
                  read_r <= shift_r[0];
                  sda_oe_r <= 1'b1;
                  state_r <= ST_ACK_A;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                sda_oe_r <= 1'b1;
                state_r <= ST_ACK_W;
                if (first_r) begin
                  // First data byte sets the pointer
                  pointer_r <= shift_r;
                  first_r <= 1'b0;
                end else begin
                  pointer_r <= pointer_r + 1'b1;
                  case (pointer_r)
                    `OFS_NORMAL: normal_r <= shift_r;
                    `OFS_ALT: alt_r <= shift_r;
                    `OFS_CTRL1: ctrl_r <= shift_r;
                    default: ;
                  endcase
                end
              end
            end
          end
          ST_ACK_A: begin
            // End of address acknowledge
            if (scl_fall) begin
              if (read_r) begin
                shift_r <= rd_data;
                sda_oe_r <= ~rd_data[7];
                bit_cnt_r <= 4'h1;
                pointer_r <= pointer_r + 1'b1;
                state_r <= ST_READ;
              end else begin
                sda_oe_r <= 1'b0;
                state_r <= ST_WRITE;
              end
            end
          end
          ST_ACK_W: begin
            // Release data after write acknowledge
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              state_r <= ST_WRITE;
            end
          end
          ST_READ: begin
            // Drive next bit on falling clock
            if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe_r <= 1'b0;
                state_r <= ST_ACK_R;
              end else begin
                sda_oe_r <= ~shift_r[6];
                shift_r <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 1'b1;
              end
            end
          end
          ST_ACK_R: begin
            // Master acknowledge decides whether to continue
            if (scl_rise) begin
              nack_r <= sda_s;
            end else if (scl_fall) begin
              if (nack_r) begin
                state_r <= ST_IDLE;
              end else begin
                shift_r <= rd_data;
                sda_oe_r <= ~rd_data[7];
                bit_cnt_r <= 4'h1;
                pointer_r <= pointer_r + 1'b1;
                state_r <= ST_READ;
              end
            end
          end
          default: begin
            // Idle: wait for a start
            sda_oe_r <= 1'b0;
          end
        endcase
      end
      if (fault_s) begin
        normal_r <= `RST_NORMAL;
        alt_r <= `RST_ALT;
        ctrl_r <= `RST_CTRL1;
      end
    end
  end

  // Control outputs derived from registers and pins
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      converter_on_r <= 1'b0;
      remote_sense_on_r <= 1'b0;
      forced_pulse_mode_r <= 1'b0;
      discharge_on_r <= 1'b0;
      bias_keep_alive_r <= 1'b0;
      switching_rate_lower_r <= 1'b0;
      ramp_rate_r <= 2'b10;
      startup_r <= 1'b1;
    end else if (clock_enable) begin
      converter_on_r <= conv_req;
      remote_sense_on_r <= ctrl_r[`BIT_SENSE];
      forced_pulse_mode_r <= ctrl_r[`BIT_FPWM] |
        (falling & ~ctrl_r[`BIT_FSR_N] & converter_on_r);
      discharge_on_r <= ctrl_r[`BIT_DISCH] & ~conv_req;
      // bias kept by bit or pin
      bias_keep_alive_r <= conv_req | ctrl_r[`BIT_BIAS] | bias_s;
      switching_rate_lower_r <= ctrl_r[`BIT_FREQ];
      ramp_rate_r <= ctrl_r[1:0];
      // Start-up rate until first settle; soft-stop while off
      startup_r <= ~converter_on_r | (startup_r & (target_code != goal));
    end
  end

  target_ramp #(
    .CODE_W(7),
    .CNT_W(4)
  ) u_ramp (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .goal(goal),
    .rate_sel(ctrl_r[1:0]),
    .startup_mode(startup_r),
    .target_r(target_code),
    .falling_r(falling)
  );

endmodule
`default_nettype wire

/* File: regulator_control_registers_chk.sv */
/*
  Port assertions for the regulator register bank.
  Assumes one clock domain; checks pause while clock_enable is low.
*/
`timescale 1ns/1ns
`default_nettype none
module regulator_control_registers_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic enable_pin,
  input wire logic bias_keep_pin,
  input wire logic supply_undervoltage_lockout,
  input wire logic thermal_shutdown,
  input wire logic converter_on_r,
  input wire logic remote_sense_on_r,
  input wire logic discharge_on_r,
  input wire logic bias_keep_alive_r,
  input wire logic switching_rate_lower_r,
  input wire logic [6:0] target_code,
  input wire logic [1:0] ramp_rate_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n || !clock_enable);
  a_pin_enable: assert property (enable_pin [*4] |-> ##1 converter_on_r)
    else $error("enable pin ignored");
  a_supply_undervoltage_lockout_defaults: assert property (supply_undervoltage_lockout [*4] |-> ##1
    (ramp_rate_r == 2'b10 && !remote_sense_on_r && !switching_rate_lower_r))
    else $error("undervoltage kept settings");
  a_thermal_defaults: assert property (thermal_shutdown [*4] |-> ##1
    (ramp_rate_r == 2'b10 && !remote_sense_on_r && !switching_rate_lower_r))
    else $error("thermal fault kept settings");
  a_disch_off: assert property (discharge_on_r |-> !converter_on_r)
    else $error("discharge while on");
  a_bias_on: assert property (converter_on_r |-> bias_keep_alive_r)
    else $error("bias off while on");
  a_bias_pin: assert property (bias_keep_pin [*4] |-> ##1 bias_keep_alive_r)
    else $error("bias pin ignored");
  a_target_step: assert property ($changed(target_code) |->
    (target_code == $past(target_code) + 7'h01 || target_code + 7'h01 == $past(target_code)))
    else $error("target jumped");
  a_step_spacing: assert property ($changed(target_code) && ramp_rate_r != 2'b11
    |=> $stable(target_code))
    else $error("ramp too fast");
  c_turn_on: cover property ($rose(converter_on_r));
  c_discharge: cover property ($rose(discharge_on_r));
  c_fault: cover property (thermal_shutdown [*4]);
endmodule
bind regulator_control_registers regulator_control_registers_chk chk (.clock, .reset_n,
  .clock_enable, .enable_pin, .bias_keep_pin, .supply_undervoltage_lockout, .thermal_shutdown,
  .converter_on_r, .remote_sense_on_r, .discharge_on_r, .bias_keep_alive_r,
  .switching_rate_lower_r, .target_code, .ramp_rate_r);
`default_nettype wire

/* File: regulator_control_registers_tb.sv */
/*
  Self-checking bench for the regulator register bank.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
`include "regulator_ctrl_regs.vh"
module regulator_control_registers_tb;
  typedef struct {
    logic [7:0] d;
    logic [6:0] e;
  } row_t;
  // Control writes and outputs while off
  row_t rows [9] = '{'{8'h80, 7'h40}, '{8'h40, 7'h20}, '{8'h10, 7'h10},
    '{8'h08, 7'h08}, '{8'h04, 7'h04}, '{8'h00, 7'h00}, '{8'h01, 7'h01},
    '{8'h03, 7'h03}, '{8'h22, 7'h02}};
  logic [7:0] dflt [3] = '{`RST_NORMAL, `RST_ALT, `RST_CTRL1};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clock_enable = 1'b1;
  logic enable_pin = 1'b0;
  logic voltage_select_pin = 1'b0;
  logic bias_keep_pin = 1'b0;
  logic [1:0] flt = 2'b00; // Thermal, undervoltage
  logic ok; // Ack result
  logic [7:0] d; // Read data
  int n; // Ramp cycles
  int fail_count = 0;
  int comparisons = 0;
  wire scl_pin, sda_low, sda_out_r, sda_oe_r, converter_on_r, remote_sense_on_r;
  wire forced_pulse_mode_r, discharge_on_r, bias_keep_alive_r, switching_rate_lower_r;
  wire [6:0] target_code;
  wire [1:0] ramp_rate_r;
  wire sda_in = !(sda_low | (sda_oe_r & !sda_out_r)); // Pulled-up line
  always #50 clock = ~clock;
  regulator_control_registers dut (.clock, .reset_n, .clock_enable, .scl_pin,
    .sda_in, .sda_out_r, .sda_oe_r, .enable_pin, .voltage_select_pin, .bias_keep_pin,
    .supply_undervoltage_lockout(flt[0]), .thermal_shutdown(flt[1]), .converter_on_r,
    .remote_sense_on_r, .forced_pulse_mode_r, .discharge_on_r, .bias_keep_alive_r,
    .switching_rate_lower_r, .target_code, .ramp_rate_r);
  host_bus_model host (.clock, .scl(scl_pin), .sda_low, .sda(sda_in));
  task automatic check(input string s, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic check_dflt;
    for (int i = 0; i < 3; i++) begin
      host.read_reg(8'(i), 1'b1, d);
      check("default", d, dflt[i]);
    end
  endtask
  // Bounded wait for a target code
  task automatic wait_code(input logic [6:0] c);
    n = 0;
    while (target_code !== c && n < 1000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #6000000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    check_dflt;
    check("rate", ramp_rate_r, 8'h02);
    $display("test reset done");
    foreach (rows[i]) begin
      host.write_reg(`OFS_CTRL1, rows[i].d, ok);
      check("ack", ok, 1'b1);
      repeat (5) @(negedge clock);
      check("outs", {remote_sense_on_r, forced_pulse_mode_r, discharge_on_r,
        bias_keep_alive_r, switching_rate_lower_r, ramp_rate_r}, rows[i].e);
      host.read_reg(`OFS_CTRL1, 1'b1, d);
      check("readback", d, rows[i].d);
    end
    $display("test rows done");
    host.write_reg(`OFS_CTRL1, 8'h10, ok);
    enable_pin = 1'b1;
    repeat (5) @(negedge clock);
    check("pin on", {converter_on_r, discharge_on_r}, 8'h02);
    enable_pin = 1'b0;
    repeat (5) @(negedge clock);
    check("pin off", {converter_on_r, discharge_on_r}, 8'h01);
    $display("test enable done");
    host.write_reg(`OFS_CTRL1, `RST_CTRL1, ok);
    host.write_reg(`OFS_NORMAL, 8'hA0, ok);
    wait_code(7'h20);
    check("normal code", {converter_on_r, target_code}, 8'hA0);
    voltage_select_pin = 1'b1;
    wait_code(7'h5F);
    check("alt code", target_code, 8'h5F);
    check("alt ramp", n >= 126 && n <= 134, 1'b1);
    voltage_select_pin = 1'b0;
    repeat (12) @(negedge clock);
    check("sink", forced_pulse_mode_r, 1'b1);
    wait_code(7'h20);
    host.write_reg(`OFS_CTRL1, 8'h22, ok);
    voltage_select_pin = 1'b1;
    wait_code(7'h5F);
    voltage_select_pin = 1'b0;
    repeat (12) @(negedge clock);
    check("no sink", forced_pulse_mode_r, 1'b0);
    // Fast slew field: one code per cycle on select changes
    wait_code(7'h20);
    host.write_reg(`OFS_CTRL1, 8'h03, ok);
    voltage_select_pin = 1'b1;
    wait_code(7'h5F);
    check("fast ramp", n >= 63 && n <= 70, 1'b1);
    voltage_select_pin = 1'b0;
    wait_code(7'h20);
    $display("test target done");
    for (int k = 1; k < 3; k++) begin
      host.write_reg(`OFS_ALT, 8'h90, ok);
      host.write_reg(`OFS_CTRL1, 8'h8D, ok);
      flt = 2'(k);
      repeat (10) @(negedge clock);
      flt = 2'b00;
      check_dflt;
    end
    $display("test fault done");
    bias_keep_pin = 1'b1;
    repeat (5) @(negedge clock);
    check("bias pin", bias_keep_alive_r, 1'b1);
    bias_keep_pin = 1'b0;
    repeat (5) @(negedge clock);
    check("bias idle", bias_keep_alive_r, 1'b0);
    // Low clock enable freezes the pin path and outputs
    clock_enable = 1'b0;
    enable_pin = 1'b1;
    repeat (5) @(negedge clock);
    check("frozen", converter_on_r, 1'b0);
    clock_enable = 1'b1;
    repeat (5) @(negedge clock);
    check("thawed", converter_on_r, 1'b1);
    enable_pin = 1'b0;
    repeat (5) @(negedge clock);
    check("pin low", converter_on_r, 1'b0);
    $display("test freeze done");
    host.write_reg(`OFS_CTRL1, 8'h83, ok);
    host.read_reg(8'h00, 1'b0, d);
    check("stop pointer", d, `RST_NORMAL);
    host.addr = 7'h1C;
    host.write_reg(`OFS_NORMAL, 8'hA1, ok);
    check("bad addr", ok, 1'b0);
    host.addr = `SLAVE_ADDR;
    host.write_reg(8'h05, 8'h55, ok);
    host.read_reg(8'h05, 1'b1, d);
    check("unmapped", d, 8'h00);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    check_dflt;
    $display("test refusal done");
    finish_test;
  end
endmodule
`default_nettype wire

/* File: regulator_ctrl_regs.vh */
/*
  Constants for the regulator control register bank: register offsets,
  reset values, field positions, slew figures and the clock period.
  Assumes it is included by bare name from the design files.
*/
`ifndef REGULATOR_CTRL_REGS_VH
`define REGULATOR_CTRL_REGS_VH

// Register offsets
`define OFS_NORMAL 8'h00
`define OFS_ALT 8'h01
`define OFS_CTRL1 8'h02
// Reset values
`define RST_NORMAL 8'h3F
`define RST_ALT 8'hDF
`define RST_CTRL1 8'h02
// Field positions
`define BIT_EN 7
`define BIT_SENSE 7
`define BIT_FPWM 6
`define BIT_FSR_N 5
`define BIT_DISCH 4
`define BIT_BIAS 3
`define BIT_FREQ 2
`define CODE_MSB 6
// Pointer value after a stop condition
`define PTR_IDLE 8'h00
// Default 7-bit slave address
`define SLAVE_ADDR 7'h1B
// Clock period in ns and one code step in uV
`define CLK_NS 100
`define CODE_STEP_UV 6250
// Slew rates in uV/us
`define RATE_START 20000
`define RATE_SEL0 12500
`define RATE_SEL1 25000
`define RATE_SEL2 50000
`define RATE_FAST 200000
// Cycles per code step, rounded up so the rate is never exceeded
`define STEP_CYC(r) ((`CODE_STEP_UV * 1000 + (r) * `CLK_NS - 1) / ((r) * `CLK_NS))

`endif

/* File: target_ramp.v */
/*
  Ramps the output target code one step at a time toward a goal code.
  Assumes goal and mode inputs come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "regulator_ctrl_regs.vh"

module target_ramp #(
  parameter CODE_W = 7,
  parameter CNT_W = 4
) (
  input wire clock,
  input wire reset_n,
  input wire clock_enable,
  input wire [CODE_W-1:0] goal,
  input wire [1:0] rate_sel,
  input wire startup_mode,
  output reg [CODE_W-1:0] target_r,
  output reg falling_r
);

  // Cycles between steps for the selected rate
  reg [CNT_W-1:0] step_cyc;
  // Cycles left until the next step
  reg [CNT_W-1:0] wait_r;

  // Step spacing per rate, cut to the counter width where used
  localparam integer CYC_FAST = `STEP_CYC(`RATE_FAST);
  localparam integer CYC_START = `STEP_CYC(`RATE_START);
  localparam integer CYC_SEL0 = `STEP_CYC(`RATE_SEL0);
  localparam integer CYC_SEL1 = `STEP_CYC(`RATE_SEL1);
  localparam integer CYC_SEL2 = `STEP_CYC(`RATE_SEL2);

  // Pick step spacing from mode and slew field
  always @* begin
    if (rate_sel == 2'b11) begin
      step_cyc = CYC_FAST[CNT_W-1:0];
    end else if (startup_mode) begin
      step_cyc = CYC_START[CNT_W-1:0];
    end else begin
      case (rate_sel)
        2'b00: step_cyc = CYC_SEL0[CNT_W-1:0];
        2'b01: step_cyc = CYC_SEL1[CNT_W-1:0];
        default: step_cyc = CYC_SEL2[CNT_W-1:0];
      endcase
    end
  end

  // Step the target toward the goal
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      target_r <= {CODE_W{1'b0}};
      wait_r <= {CNT_W{1'b0}};
      falling_r <= 1'b0;
    end else if (clock_enable) begin
      falling_r <= (target_r > goal);
      if (target_r == goal) begin
        // Settled: next change steps promptly
        wait_r <= {CNT_W{1'b0}};
      end else if (wait_r != {CNT_W{1'b0}}) begin
        wait_r <= wait_r - 1'b1;
      end else begin
        wait_r <= step_cyc - 1'b1;
        if (target_r < goal) begin
          target_r <= target_r + 1'b1;
        end else begin
          target_r <= target_r - 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire
